// ==== rtl/timer_pkg.sv ====
/*
 Shared constants for the timer channel: register indices, field
 positions, reset values and field encodings.
 Assumes a 32-bit AXI4-Lite slave where byte address = 4 * index.
*/
package timer_pkg;
  localparam int unsigned AXI_AW        = 10;
  localparam int unsigned CHANNELS      = 5;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  SYNC_SEL_IDX  = 8'h61;
  localparam logic [7:0]  MODE_SEL_IDX  = 8'h62;
  localparam logic [7:0]  IO_CTRL_IDX   = 8'h65;
  localparam logic [7:0]  COUNT_IDX     = 8'h68;
  localparam logic [7:0]  GEN_A_IDX     = 8'h6A;
  localparam logic [7:0]  GEN_B_IDX     = 8'h6C;
  localparam logic [7:0]  CTRL_IDX      = 8'h70;
  // Field positions
  localparam int unsigned CCLR_LSB      = 5;
  localparam int unsigned CKEG_LSB      = 3;
  localparam int unsigned TPSC_LSB      = 0;
  localparam int unsigned IOB_LSB       = 4;
  localparam int unsigned IOA_LSB       = 0;
  localparam int unsigned CMD_LSB       = 4;
  // Reserved bits that read as one
  localparam logic [7:0]  CTRL_RSVD     = 8'h80;
  localparam logic [7:0]  IO_CTRL_RSVD  = 8'h88;
  // Reset values
  localparam logic [1:0]  CCLR_RST      = 2'h0;
  localparam logic [1:0]  CKEG_RST      = 2'h0;
  localparam logic [2:0]  TPSC_RST      = 3'h0;
  localparam logic [2:0]  IO_RST        = 3'h0;
  localparam logic [4:0]  SYNC_SEL_RST  = 5'h00;
  localparam logic [6:0]  MODE_SEL_RST  = 7'h00;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [15:0] GEN_RST       = 16'hFFFF;
  // Counter clear sources
  localparam logic [1:0]  CLR_NONE      = 2'h0;
  localparam logic [1:0]  CLR_A         = 2'h1;
  localparam logic [1:0]  CLR_B         = 2'h2;
  localparam logic [1:0]  CLR_SYNC      = 2'h3;
  // Edge choice: 00 rising, 01 falling, 1x both
  localparam logic [1:0]  EDGE_RISE     = 2'h0;
  localparam logic [1:0]  EDGE_FALL     = 2'h1;
  // Compare output actions
  localparam logic [1:0]  OUT_NONE      = 2'h0;
  localparam logic [1:0]  OUT_LOW       = 2'h1;
  localparam logic [1:0]  OUT_HIGH      = 2'h2;
  // Channel 3/4 combination modes and AXI response codes
  localparam logic [1:0]  CMD_COMPL     = 2'h2;
  localparam logic [1:0]  CMD_RSYNC     = 2'h3;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// ==== rtl/tick_divider.sv ====
/*
 Divider producing one-cycle count enables at 1/1, 1/2, 1/4, ... of clk.
 Assumes a single clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int unsigned STAGES = 4
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  output logic [STAGES-1:0]      tick_en
);
  typedef struct packed {
    logic [STAGES-2:0] cnt;
  } div_state_s;

  div_state_s q;
  div_state_s d;

  if (STAGES < 2) begin : g_bad
    $error("tick_divider needs at least two stages");
  end

  always_comb begin
    d = q;
    d.cnt = q.cnt + 1'b1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_en[0] = 1'b1;
  for (genvar k = 1; k < STAGES; k++) begin : g_tap
    // Rate 1/2^k: one pulse when the low k bits are all ones
    assign tick_en[k] = &q.cnt[k-1:0];
  end
endmodule
`default_nettype wire

// ==== rtl/pin_edge.sv ====
/*
 Two-flop synchroniser and edge selector for one asynchronous pin.
 Assumes edge_sel comes from the clk domain; pulse is one cycle wide.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_edge (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       pin_in,
  input  wire logic [1:0] edge_sel,
  output logic            pulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_state_s;

  sync_state_s q;
  sync_state_s d;
  logic        rise;
  logic        fall;

  always_comb begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise = q.s2 && !q.s3;
  assign fall = !q.s2 && q.s3;
  assign pulse = edge_sel[1] ? (rise || fall) :
                 (edge_sel[0] ? fall : rise);

  chk_edge_rise_only: assert property (
    @(posedge clk) disable iff (!resetn)
    (edge_sel == timer_pkg::EDGE_RISE && pulse) |-> (q.s2 && !$past(q.s2)))
    else $error("rising-only selection pulsed on a non-rising edge");
endmodule
`default_nettype wire

// ==== rtl/timer_channel.sv ====
/*
 One 16-bit timer channel: count source and edge choice, clear source,
 compare outputs, input capture and the channel 3/4 pairing mode bits,
 with its registers on an AXI4-Lite slave.
 Assumes pins and external clocks are asynchronous; sync_clear_in comes
 from sibling channels on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_channel #(
  parameter int unsigned CHAN = 0
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [9:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [9:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [3:0]  ext_clk_in,
  input  wire logic        pin_a_in,
  output logic             pin_a_out,
  output logic             pin_a_oe_n,
  input  wire logic        pin_b_in,
  output logic             pin_b_out,
  output logic             pin_b_oe_n,
  input  wire logic        sync_clear_in,
  output logic             sync_clear_out,
  output logic             pair_complementary,
  output logic             pair_reset_sync
);
  typedef struct packed {
    logic [1:0]  clr_sel;
    logic [1:0]  edge_sel;
    logic [2:0]  src_sel;
    logic [2:0]  io_b;
    logic [2:0]  io_a;
    logic [4:0]  sync_sel;
    logic [6:0]  mode_sel;
    logic [15:0] count;
    logic [15:0] gen_a;
    logic [15:0] gen_b;
    logic        pin_a;
    logic        pin_b;
    logic        pair_c;
    logic        pair_r;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [15:0] wd;
    logic [1:0]  ws;
    logic        bv;
    logic        berr;
    logic        rv;
    logic        rerr;
    logic [15:0] rd;
  } chan_state_s;

  if (CHAN >= timer_pkg::CHANNELS) begin : g_bad
    $error("timer_channel index out of range");
  end

  function automatic logic mapped(input logic [7:0] idx);
    mapped = idx inside {timer_pkg::SYNC_SEL_IDX, timer_pkg::MODE_SEL_IDX,
                         timer_pkg::IO_CTRL_IDX, timer_pkg::COUNT_IDX,
                         timer_pkg::GEN_A_IDX, timer_pkg::GEN_B_IDX,
                         timer_pkg::CTRL_IDX};
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] val,
                                          input logic [1:0]  strb);
    merge16 = {strb[1] ? val[15:8] : old[15:8], strb[0] ? val[7:0] : old[7:0]};
  endfunction

  function automatic logic cmp_out(input logic [1:0] act, input logic cur);
    unique case (act)
      timer_pkg::OUT_NONE: cmp_out = cur;
      timer_pkg::OUT_LOW:  cmp_out = 1'b0;
      timer_pkg::OUT_HIGH: cmp_out = 1'b1;
      default:             cmp_out = !cur;
    endcase
  endfunction

  chan_state_s q;
  chan_state_s d;
  logic [3:0]  div_en;
  logic [3:0]  ext_pulse;
  logic        cap_pulse_a;
  logic        cap_pulse_b;
  logic        tick;
  logic        match_a;
  logic        match_b;
  logic        cap_a;
  logic        cap_b;
  logic        sync_clr;
  logic        clr;
  logic        have_aw;
  logic        have_w;
  logic        wr;
  logic [7:0]  widx;
  logic [15:0] wval;
  logic [1:0]  wsel;
  logic [7:0]  ridx;
  logic        cnt_wr;
  logic        ga_wr;

  tick_divider #(
    .STAGES (4)
  ) u_div (
    .clk     (clk),
    .resetn  (resetn),
    .tick_en (div_en)
  );

  for (genvar k = 0; k < 4; k++) begin : g_ext
    pin_edge u_ext (
      .clk      (clk),
      .resetn   (resetn),
      .pin_in   (ext_clk_in[k]),
      .edge_sel (q.edge_sel),
      .pulse    (ext_pulse[k])
    );
  end

  pin_edge u_cap_a (
    .clk      (clk),
    .resetn   (resetn),
    .pin_in   (pin_a_in),
    .edge_sel (q.io_a[1:0]),
    .pulse    (cap_pulse_a)
  );

  pin_edge u_cap_b (
    .clk      (clk),
    .resetn   (resetn),
    .pin_in   (pin_b_in),
    .edge_sel (q.io_b[1:0]),
    .pulse    (cap_pulse_b)
  );

  always_comb begin
    d = q;
    // Internal rates for codes 0xx, external pins for 1xx
    tick = q.src_sel[2] ? ext_pulse[q.src_sel[1:0]] : div_en[q.src_sel[1:0]];
    match_a = tick && !q.io_a[2] && (q.count == q.gen_a);
    match_b = tick && !q.io_b[2] && (q.count == q.gen_b);
    cap_a = q.io_a[2] && cap_pulse_a;
    cap_b = q.io_b[2] && cap_pulse_b;
    sync_clr = (q.clr_sel == timer_pkg::CLR_SYNC) && q.sync_sel[CHAN] && sync_clear_in;
    clr = ((q.clr_sel == timer_pkg::CLR_A) && (match_a || cap_a)) ||
          ((q.clr_sel == timer_pkg::CLR_B) && (match_b || cap_b)) || sync_clr;
    if (clr) begin
      d.count = timer_pkg::COUNT_RST;
    end else if (tick) begin
      d.count = q.count + 16'h0001;
    end
    if (cap_a) begin
      d.gen_a = q.count;
    end
    if (cap_b) begin
      d.gen_b = q.count;
    end
    if (match_a) begin
      d.pin_a = cmp_out(q.io_a[1:0], q.pin_a);
    end
    if (match_b) begin
      d.pin_b = cmp_out(q.io_b[1:0], q.pin_b);
    end
    d.pair_c = q.mode_sel[timer_pkg::CMD_LSB+1 -: 2] == timer_pkg::CMD_COMPL;
    d.pair_r = q.mode_sel[timer_pkg::CMD_LSB+1 -: 2] == timer_pkg::CMD_RSYNC;

    // Write: address and data taken in either order, answered together
    have_aw = q.aw_got || (awvalid && awready);
    have_w = q.w_got || (wvalid && wready);
    widx = q.aw_got ? q.waddr : awaddr[9:2];
    wval = q.w_got ? q.wd : wdata[15:0];
    wsel = q.w_got ? q.ws : wstrb[1:0];
    wr = have_aw && have_w && !q.bv;
    cnt_wr = wr && (widx == timer_pkg::COUNT_IDX);
    ga_wr = wr && (widx == timer_pkg::GEN_A_IDX);
    if (awvalid && awready) begin
      d.aw_got = 1'b1;
      d.waddr = awaddr[9:2];
    end
    if (wvalid && wready) begin
      d.w_got = 1'b1;
      d.wd = wdata[15:0];
      d.ws = wstrb[1:0];
    end
    if (wr) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bv = 1'b1;
      d.berr = !mapped(widx);
      // Software writes win over same-cycle hardware updates
      if (wsel[0]) begin
        unique case (widx)
          timer_pkg::SYNC_SEL_IDX: d.sync_sel = wval[4:0];
          timer_pkg::MODE_SEL_IDX: d.mode_sel = wval[6:0];
          timer_pkg::IO_CTRL_IDX: begin
            d.io_b = wval[timer_pkg::IOB_LSB +: 3];
            d.io_a = wval[timer_pkg::IOA_LSB +: 3];
          end
          timer_pkg::CTRL_IDX: begin
            d.clr_sel = wval[timer_pkg::CCLR_LSB +: 2];
            d.edge_sel = wval[timer_pkg::CKEG_LSB +: 2];
            d.src_sel = wval[timer_pkg::TPSC_LSB +: 3];
          end
          default: ;
        endcase
      end
      if (widx == timer_pkg::COUNT_IDX) begin
        d.count = merge16(q.count, wval, wsel);
      end
      if (widx == timer_pkg::GEN_A_IDX) begin
        d.gen_a = merge16(q.gen_a, wval, wsel);
      end
      if (widx == timer_pkg::GEN_B_IDX) begin
        d.gen_b = merge16(q.gen_b, wval, wsel);
      end
    end
    if (q.bv && bready) begin
      d.bv = 1'b0;
    end

    // Read: one word at a time, data held until taken
    ridx = araddr[9:2];
    if (arvalid && arready) begin
      d.rv = 1'b1;
      d.rerr = !mapped(ridx);
      unique case (ridx)
        timer_pkg::SYNC_SEL_IDX: d.rd = {11'h000, q.sync_sel};
        timer_pkg::MODE_SEL_IDX: d.rd = {9'h000, q.mode_sel};
        timer_pkg::IO_CTRL_IDX:  d.rd = {8'h00, timer_pkg::IO_CTRL_RSVD} |
                                         {9'h000, q.io_b, 1'b0, q.io_a};
        timer_pkg::CTRL_IDX:     d.rd = {8'h00, timer_pkg::CTRL_RSVD} |
                                         {9'h000, q.clr_sel, q.edge_sel, q.src_sel};
        timer_pkg::COUNT_IDX:    d.rd = q.count;
        timer_pkg::GEN_A_IDX:    d.rd = q.gen_a;
        timer_pkg::GEN_B_IDX:    d.rd = q.gen_b;
        default:                 d.rd = 16'h0000;
      endcase
    end else if (q.rv && rready) begin
      d.rv = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.clr_sel <= timer_pkg::CCLR_RST;
      q.edge_sel <= timer_pkg::CKEG_RST;
      q.src_sel <= timer_pkg::TPSC_RST;
      q.io_a <= timer_pkg::IO_RST;
      q.io_b <= timer_pkg::IO_RST;
      q.sync_sel <= timer_pkg::SYNC_SEL_RST;
      q.mode_sel <= timer_pkg::MODE_SEL_RST;
      q.count <= timer_pkg::COUNT_RST;
      q.gen_a <= timer_pkg::GEN_RST;
      q.gen_b <= timer_pkg::GEN_RST;
    end else begin
      q <= d;
    end
  end

  assign awready = !q.aw_got && !q.bv;
  assign wready = !q.w_got && !q.bv;
  assign bvalid = q.bv;
  assign bresp = q.berr ? timer_pkg::RESP_SLVERR : timer_pkg::RESP_OKAY;
  assign arready = !q.rv;
  assign rvalid = q.rv;
  assign rresp = q.rerr ? timer_pkg::RESP_SLVERR : timer_pkg::RESP_OKAY;
  assign rdata = {16'h0000, q.rd};
  assign pin_a_out = q.pin_a;
  assign pin_b_out = q.pin_b;
  // Pin left undriven in capture mode and for "no output"
  assign pin_a_oe_n = q.io_a[2] || (q.io_a[1:0] == timer_pkg::OUT_NONE);
  assign pin_b_oe_n = q.io_b[2] || (q.io_b[1:0] == timer_pkg::OUT_NONE);
  // Own A/B clears drive the synchronized group
  assign sync_clear_out = q.sync_sel[CHAN] && clr && !sync_clr;
  assign pair_complementary = q.pair_c;
  assign pair_reset_sync = q.pair_r;

  chk_clear_on_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (q.clr_sel == timer_pkg::CLR_A && match_a && !cnt_wr) |=> (q.count == 16'h0000))
    else $error("count not cleared on register A match");

  chk_never_clear: assert property (
    @(posedge clk) disable iff (!resetn)
    (q.clr_sel == timer_pkg::CLR_NONE && tick && !cnt_wr)
      |=> (q.count == $past(q.count) + 16'h0001))
    else $error("count did not advance with clearing off");

  chk_sync_clear: assert property (
    @(posedge clk) disable iff (!resetn)
    (q.clr_sel == timer_pkg::CLR_SYNC && q.sync_sel[CHAN] && sync_clear_in && !cnt_wr)
      |=> (q.count == 16'h0000))
    else $error("synchronized clear missed");

  chk_pair_off: assert property (
    @(posedge clk) disable iff (!resetn)
    (!q.mode_sel[timer_pkg::CMD_LSB+1] && $stable(q.mode_sel))
      |=> (!pair_complementary && !pair_reset_sync))
    else $error("channels 3 and 4 paired in normal mode");

  chk_pair_compl: assert property (
    @(posedge clk) disable iff (!resetn)
    (q.mode_sel[timer_pkg::CMD_LSB+1 -: 2] == timer_pkg::CMD_COMPL)
      |=> (pair_complementary && !pair_reset_sync))
    else $error("complementary pairing not shown");

  chk_pair_rsync: assert property (
    @(posedge clk) disable iff (!resetn)
    (q.mode_sel[timer_pkg::CMD_LSB+1 -: 2] == timer_pkg::CMD_RSYNC)
      |=> (pair_reset_sync && !pair_complementary))
    else $error("reset-synchronized pairing not shown");

  chk_toggle_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (match_a && q.io_a == 3'h3) |=> (pin_a_out != $past(pin_a_out)))
    else $error("pin A did not toggle on match");

  chk_capture_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (cap_a && !ga_wr) |=> (q.gen_a == $past(q.count)))
    else $error("register A did not capture the count");

  chk_count_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    (!tick && !clr && !cnt_wr) |=> $stable(q.count))
    else $error("count moved without an event");
endmodule
`default_nettype wire

// ==== verif/timer_far_side.sv ====
/*
 Far side of the timer channel: external count clocks and the two
 capture/compare pins.
 Assumes clk is the channel clock; pins resolve from the channel's enables.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_far_side (
  input  wire logic       clk,
  input  wire logic       pin_a_out,
  input  wire logic       pin_a_oe_n,
  input  wire logic       pin_b_out,
  input  wire logic       pin_b_oe_n,
  output logic [3:0]      ext_clk_in,
  output logic            pin_a_in,
  output logic            pin_b_in
);
  logic a_drv;
  logic b_drv;

  // Wire level: channel wins while it drives
  assign pin_a_in = pin_a_oe_n ? a_drv : pin_a_out;
  assign pin_b_in = pin_b_oe_n ? b_drv : pin_b_out;

  initial begin
    ext_clk_in = 4'h0;
    a_drv      = 1'b0;
    b_drv      = 1'b0;
  end

  // Clock stands low between bursts; hold sets prompt or slow edges
  task automatic ext_pulses(input int idx, input int n, input int hold);
    repeat (n) begin
      repeat (hold) @(posedge clk);
      ext_clk_in[idx] <= 1'b1;
      repeat (hold) @(posedge clk);
      ext_clk_in[idx] <= 1'b0;
    end
    repeat (6) @(posedge clk);
  endtask

  task automatic set_pin(input logic is_b, input logic lvl);
    @(posedge clk);
    if (is_b) begin
      b_drv <= lvl;
    end else begin
      a_drv <= lvl;
    end
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== verif/timer_channel_mode_control_test.sv ====
/*
 Self-checking bench for one timer channel: register access over
 AXI4-Lite, clear sources, count edges, pairing modes, compare and capture.
 Assumes the far-side model drives external clocks and pins.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_channel_mode_control_test;
  logic        clk;
  logic        resetn;
  logic [9:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [9:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [3:0]  ext_clk_in;
  logic        pin_a_in;
  logic        pin_a_out;
  logic        pin_a_oe_n;
  logic        pin_b_in;
  logic        pin_b_out;
  logic        pin_b_oe_n;
  logic        sync_clear_in;
  logic        sync_clear_out;
  logic        pair_complementary;
  logic        pair_reset_sync;
  logic        saw_sync_out = 1'b0;
  int          miscompares;
  int          cmp_count;
  logic [31:0] d;
  logic [1:0]  r;

  timer_channel #(.CHAN(0)) dut (
    .clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ext_clk_in(ext_clk_in), .pin_a_in(pin_a_in), .pin_a_out(pin_a_out),
    .pin_a_oe_n(pin_a_oe_n), .pin_b_in(pin_b_in), .pin_b_out(pin_b_out),
    .pin_b_oe_n(pin_b_oe_n), .sync_clear_in(sync_clear_in),
    .sync_clear_out(sync_clear_out), .pair_complementary(pair_complementary),
    .pair_reset_sync(pair_reset_sync));

  timer_far_side far (
    .clk(clk), .pin_a_out(pin_a_out), .pin_a_oe_n(pin_a_oe_n), .pin_b_out(pin_b_out),
    .pin_b_oe_n(pin_b_oe_n), .ext_clk_in(ext_clk_in), .pin_a_in(pin_a_in),
    .pin_b_in(pin_b_in));

  always #4 clk = ~clk;

  always @(posedge clk) begin
    if (sync_clear_out) begin
      saw_sync_out <= 1'b1;
    end
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Each channel released on its own handshake edge
  task automatic axi_write(input logic [7:0] idx, input logic [15:0] val,
                           output logic [1:0] resp);
    @(posedge clk);
    awaddr  <= {idx, 2'h0};
    awvalid <= 1'b1;
    wdata   <= {16'h0000, val};
    wstrb   <= 4'h3;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] idx, output logic [31:0] data,
                          output logic [1:0] resp);
    @(posedge clk);
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] val);
    logic [1:0] ignore;
    axi_write(idx, val, ignore);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0]  rs;
    axi_read(idx, v, rs);
    check(v, exp);
  endtask

  function automatic logic [15:0] ctl(input logic [1:0] clr, input logic [1:0] edg,
                                      input logic [2:0] src);
    return {8'h00, 1'b0, clr, edg, src};
  endfunction

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, sync_clear_in} = '0;
    miscompares = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(timer_pkg::CTRL_IDX, 32'h0000_0080);
    rd_chk(timer_pkg::IO_CTRL_IDX, 32'h0000_0088);
    rd_chk(timer_pkg::MODE_SEL_IDX, 32'h0000_0000);
    rd_chk(timer_pkg::SYNC_SEL_IDX, 32'h0000_0000);
    rd_chk(timer_pkg::GEN_A_IDX, 32'h0000_FFFF);
    axi_read(8'h40, d, r);
    check(32'(r), 32'(timer_pkg::RESP_SLVERR));
    check(d, 32'h0000_0000);
    axi_write(8'h41, 16'h1234, r);
    check(32'(r), 32'(timer_pkg::RESP_SLVERR));
    // Clear sources: 7 rising edges, A=3, B=5
    wr(timer_pkg::GEN_A_IDX, 16'h0003);
    wr(timer_pkg::GEN_B_IDX, 16'h0005);
    for (int c = 0; c < 3; c++) begin
      wr(timer_pkg::CTRL_IDX, ctl(2'(c), 2'h0, 3'h4));
      wr(timer_pkg::COUNT_IDX, 16'h0000);
      far.ext_pulses(0, 7, 2 + c);
      rd_chk(timer_pkg::COUNT_IDX, (c == 0) ? 32'h7 : (c == 1) ? 32'h3 : 32'h1);
    end
    // Every edge code, each on its own external pin
    for (int e = 0; e < 4; e++) begin
      wr(timer_pkg::CTRL_IDX, ctl(2'h0, 2'(e), 3'(4 + e)));
      wr(timer_pkg::COUNT_IDX, 16'h0000);
      far.ext_pulses(e, 3, 2 + e);
      rd_chk(timer_pkg::COUNT_IDX, (e >= 2) ? 32'h6 : 32'h3);
    end
    // Internal clk/1 source: three ticks from the count write to the stop write
    wr(timer_pkg::CTRL_IDX, ctl(2'h0, 2'h0, 3'h0));
    wr(timer_pkg::COUNT_IDX, 16'h0000);
    wr(timer_pkg::CTRL_IDX, ctl(2'h0, 2'h0, 3'h4));
    rd_chk(timer_pkg::COUNT_IDX, 32'h0000_0003);
    // Synchronized clear only with clear field 11
    wr(timer_pkg::SYNC_SEL_IDX, 16'h0001);
    wr(timer_pkg::CTRL_IDX, ctl(2'h1, 2'h0, 3'h4));
    wr(timer_pkg::COUNT_IDX, 16'h0010);
    @(posedge clk) sync_clear_in <= 1'b1;
    @(posedge clk) sync_clear_in <= 1'b0;
    rd_chk(timer_pkg::COUNT_IDX, 32'h0000_0010);
    wr(timer_pkg::COUNT_IDX, 16'h0000);
    far.ext_pulses(0, 4, 2);
    check(32'(saw_sync_out), 32'h0000_0001);
    wr(timer_pkg::CTRL_IDX, ctl(2'h3, 2'h0, 3'h4));
    wr(timer_pkg::COUNT_IDX, 16'h0010);
    @(posedge clk) sync_clear_in <= 1'b1;
    @(posedge clk) sync_clear_in <= 1'b0;
    rd_chk(timer_pkg::COUNT_IDX, 32'h0000_0000);
    wr(timer_pkg::SYNC_SEL_IDX, 16'h0000);
    // Pairing modes, all four codes
    for (int m = 0; m < 4; m++) begin
      wr(timer_pkg::MODE_SEL_IDX, 16'(m << 4));
      repeat (2) @(posedge clk);
      check(32'({pair_complementary, pair_reset_sync}), 32'({m == 2, m == 3}));
    end
    // Compare outputs: drive 1, drive 0, then toggle from 0
    wr(timer_pkg::CTRL_IDX, ctl(2'h0, 2'h0, 3'h4));
    wr(timer_pkg::GEN_A_IDX, 16'h0002);
    wr(timer_pkg::GEN_B_IDX, 16'h0002);
    for (int i = 0; i < 3; i++) begin
      wr(timer_pkg::IO_CTRL_IDX, (i == 0) ? 16'h0022 : (i == 1) ? 16'h0011 : 16'h0033);
      wr(timer_pkg::COUNT_IDX, 16'h0000);
      far.ext_pulses(0, 3, 3);
      check(32'({pin_b_oe_n, pin_b_out, pin_a_oe_n, pin_a_out}), 32'({2{1'b0, i != 1}}));
    end
    wr(timer_pkg::IO_CTRL_IDX, 16'h0000);
    check(32'({pin_b_oe_n, pin_a_oe_n}), 32'h0000_0003);
    // Capture: A on rising only, B on both edges
    wr(timer_pkg::IO_CTRL_IDX, 16'h0064);
    wr(timer_pkg::COUNT_IDX, 16'h0007);
    far.set_pin(1'b0, 1'b1);
    rd_chk(timer_pkg::GEN_A_IDX, 32'h0000_0007);
    wr(timer_pkg::COUNT_IDX, 16'h0009);
    far.set_pin(1'b1, 1'b1);
    rd_chk(timer_pkg::GEN_B_IDX, 32'h0000_0009);
    wr(timer_pkg::COUNT_IDX, 16'h0004);
    far.set_pin(1'b1, 1'b0);
    rd_chk(timer_pkg::GEN_B_IDX, 32'h0000_0004);
    far.set_pin(1'b0, 1'b0);
    rd_chk(timer_pkg::GEN_A_IDX, 32'h0000_0007);
    tally_and_finish();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
